/* File: logic/uart_port_pkg.sv */
// shared constants for the quad uart host port and its host end
package uart_port_pkg;
  // ------------------------------------------------------------
  // sizes and timing
  // ------------------------------------------------------------
  localparam int N_CHAN       = 4;
  localparam int FIFO_DEPTH   = 16;
  localparam int CLK_NS       = 100;
  localparam int RST_MIN_NS   = 40;
  // least time rounds up, never below one cycle
  localparam int RST_MIN_RAW  = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_MIN_CYC  = (RST_MIN_RAW < 1) ? 1 : RST_MIN_RAW;
  localparam int RST_DRIVE_CYC = RST_MIN_CYC + 1;
  localparam int STROBE_CYC   = 3;
  // ------------------------------------------------------------
  // per-channel register offsets
  // ------------------------------------------------------------
  localparam logic [2:0] REG_DATA   = 3'h0;
  localparam logic [2:0] REG_IEN    = 3'h1;
  localparam logic [2:0] REG_FCTL   = 3'h2;
  localparam logic [2:0] REG_LCTL   = 3'h3;
  localparam logic [2:0] REG_MCTL   = 3'h4;
  localparam logic [2:0] REG_LSTAT  = 3'h5;
  localparam logic [2:0] REG_MSTAT  = 3'h6;
  localparam logic [2:0] REG_SCRATCH = 3'h7;
  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int IEN_RX_BIT    = 0;
  localparam int IEN_TX_BIT    = 1;
  localparam int FCTL_RXCLR_BIT = 1;
  localparam int FCTL_TXCLR_BIT = 2;
  localparam int LCTL_BREAK_BIT = 6;
  localparam int MCTL_IRQEN_BIT = 3;
  localparam int MCTL_LOOP_BIT  = 4;
  localparam logic [7:0] REG_RST = 8'h00;
endpackage

/* File: logic/uart_port_if.sv */
// host port wires between the quad uart and its host
`timescale 1ns/1ps
`default_nettype none
interface uart_port_if;
  logic       strap_val;
  logic       strap_oe;
  logic       irq_style_strap;
  logic       reset_pin;
  logic       read_strobe_n;
  logic       write_strobe_n;
  logic       chan_a_select_n;
  logic       chan_b_select_n;
  logic       chan_c_select_n;
  logic       chan_d_select_n;
  logic       unit_select_n;
  logic       read_write_n;
  logic       chan_addr_lo;
  logic       chan_addr_hi;
  logic [2:0] reg_addr;
  logic [7:0] hdata;
  logic       hdata_oe;
  logic [7:0] ddata;
  logic       ddata_oe;
  logic [3:0] irq;
  logic [3:0] irq_oe;
  wire        bus_style;
  wire  [7:0] data_bus;
  // ------------------------------------------------------------
  // wire resolution
  // ------------------------------------------------------------
  // undriven strap floats high through the pull-up
  // strap pull-up
  assign bus_style = strap_oe ? strap_val : 1'b1;
  assign data_bus  = ddata_oe ? ddata : (hdata_oe ? hdata : 8'hFF);
  modport dev (
    input  bus_style, irq_style_strap, reset_pin, read_strobe_n, write_strobe_n,
    input  chan_a_select_n, chan_b_select_n, chan_c_select_n, chan_d_select_n,
    input  unit_select_n, read_write_n, chan_addr_lo, chan_addr_hi, reg_addr,
    input  data_bus,
    output ddata, ddata_oe, irq, irq_oe
  );
  modport host (
    output strap_val, strap_oe, irq_style_strap, reset_pin, read_strobe_n,
    output write_strobe_n, chan_a_select_n, chan_b_select_n, chan_c_select_n,
    output chan_d_select_n, unit_select_n, read_write_n, chan_addr_lo,
    output chan_addr_hi, reg_addr, hdata, hdata_oe,
    input  data_bus, bus_style, ddata_oe, irq, irq_oe
  );
endinterface
`default_nettype wire

/* File: logic/quad_uart_port.sv */
// quad uart device end: shared host port, strap modes, channel registers
// Functional notes
// - strap high strobe bus, low rw bus
// - unconnected bus strap reads as high
// - strobe mode: high reset pulse, min 40ns
// - in reset tx high, rx ignored
// - rw mode: low reset pulse, min 40ns
// - strobe mode uses strobes plus four selects
// - rw mode uses direction, select, address bits
// - four channels, each own register set
// - each channel 16-byte tx and rx fifo
// - strobe mode: strap, control bit3 pick irq
// - irq strap high: irq always driven
// - irq strap low: bit3 enables irq drive
// - low select picks channel; no all-read
// - rw mode address bits pick channel
// - transactions follow select and strobe edges
`timescale 1ns/1ps
`default_nettype none
module quad_uart_port (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  uart_port_if.dev        link,
  input  wire logic [3:0] ser_rx_i,
  output logic      [3:0] ser_tx_o
);
  localparam int NC = uart_port_pkg::N_CHAN;
  localparam int FD = uart_port_pkg::FIFO_DEPTH;

  // ------------------------------------------------------------
  // reset pin qualification
  // ------------------------------------------------------------
  logic [3:0] rst_cnt_q, rst_cnt_d;
  logic       pin_act, pin_rst, rst, strobe_mode_q;
  assign pin_act   = link.bus_style ? link.reset_pin : ~link.reset_pin;
  assign rst_cnt_d = (rst_cnt_q < 4'(uart_port_pkg::RST_MIN_CYC)) ? rst_cnt_q + 4'h1
                                                                   : rst_cnt_q;
  assign pin_rst   = rst_cnt_q >= 4'(uart_port_pkg::RST_MIN_CYC);
  assign rst       = ~nrst_i | pin_rst;

  // width counter, so a glitch shorter than the least pulse is dropped
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i || !pin_act)
      rst_cnt_q <= 4'h0;
    else
      rst_cnt_q <= rst_cnt_d;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst)
      strobe_mode_q <= link.bus_style;
  end

  // ------------------------------------------------------------
  // host bus decode
  // ------------------------------------------------------------
  logic [3:0] sel_strobe, sel_rw, sel, lat_sel_q;
  logic       rd, wr, act, one_hot, act_q, lat_wr_q, commit;
  logic [2:0] lat_addr_q;
  logic [7:0] lat_data_q;
  assign sel_strobe = ~{link.chan_d_select_n, link.chan_c_select_n,
                        link.chan_b_select_n, link.chan_a_select_n};
  assign sel_rw     = link.unit_select_n ? 4'h0 :
                      4'h1 << {link.chan_addr_hi, link.chan_addr_lo};
  assign sel = strobe_mode_q ? sel_strobe : sel_rw;
  assign rd  = strobe_mode_q ? (~link.read_strobe_n & |sel)
                             : (~link.unit_select_n & link.read_write_n);
  assign wr  = strobe_mode_q ? (~link.write_strobe_n & |sel)
                             : (~link.unit_select_n & ~link.read_write_n);
  assign act = rd | wr;
  assign one_hot = (sel != 4'h0) && ((sel & (sel - 4'h1)) == 4'h0);
  assign commit  = act_q & ~act;

  // address and data held while the cycle is open, used at its end
  always_ff @(posedge clk_i)
  begin
    if (rst)
    begin
      act_q      <= 1'b0;
      lat_wr_q   <= 1'b0;
      lat_sel_q  <= 4'h0;
      lat_addr_q <= 3'h0;
      lat_data_q <= 8'h00;
    end
    else
    begin
      act_q <= act;
      if (act)
      begin
        lat_wr_q   <= wr;
        lat_sel_q  <= sel;
        lat_addr_q <= link.reg_addr;
        lat_data_q <= link.data_bus;
      end
    end
  end

  // ------------------------------------------------------------
  // channels
  // ------------------------------------------------------------
  logic [7:0] rval [NC];
  logic [NC-1:0] irq_src;
  logic [NC-1:0] irq_en;
  for (genvar c = 0; c < NC; c++)
  begin : g_chan
    logic [7:0] ien_q, lctl_q, mctl_q, spr_q;
    logic [7:0] txm [FD];
    logic [7:0] rxm [FD];
    logic [3:0] txw_q, txr_q, rxw_q, rxr_q;
    logic [4:0] txn_q, rxn_q;
    logic       rxl_q;
    logic       wsel, tx_push, tx_pop, rx_push, rx_pop, tx_clr, rx_clr, mv;
    logic       tx_full, rx_full, tx_empty, rx_empty;
    assign wsel     = commit & lat_wr_q & lat_sel_q[c];
    assign tx_full  = txn_q == 5'(FD);
    assign rx_full  = rxn_q == 5'(FD);
    assign tx_empty = txn_q == 5'h00;
    assign rx_empty = rxn_q == 5'h00;
    // loopback moves transmit bytes straight into receive
    assign mv       = mctl_q[uart_port_pkg::MCTL_LOOP_BIT] & ~tx_empty & ~rx_full;
    assign tx_clr   = wsel && lat_addr_q == uart_port_pkg::REG_FCTL &&
                      lat_data_q[uart_port_pkg::FCTL_TXCLR_BIT];
    assign rx_clr   = wsel && lat_addr_q == uart_port_pkg::REG_FCTL &&
                      lat_data_q[uart_port_pkg::FCTL_RXCLR_BIT];
    assign tx_push  = wsel && lat_addr_q == uart_port_pkg::REG_DATA && ~tx_full;
    assign tx_pop   = mv;
    assign rx_push  = mv;
    assign rx_pop   = commit && ~lat_wr_q && lat_sel_q[c] &&
                      lat_addr_q == uart_port_pkg::REG_DATA && ~rx_empty;
    always_ff @(posedge clk_i)
    begin
      if (rst)
      begin
        ien_q  <= uart_port_pkg::REG_RST;
        lctl_q <= uart_port_pkg::REG_RST;
        mctl_q <= uart_port_pkg::REG_RST;
        spr_q  <= uart_port_pkg::REG_RST;
      end
      else if (wsel)
      begin
        if (lat_addr_q == uart_port_pkg::REG_IEN)
          ien_q <= lat_data_q;
        if (lat_addr_q == uart_port_pkg::REG_LCTL)
          lctl_q <= lat_data_q;
        if (lat_addr_q == uart_port_pkg::REG_MCTL)
          mctl_q <= lat_data_q;
        if (lat_addr_q == uart_port_pkg::REG_SCRATCH)
          spr_q <= lat_data_q;
      end
    end

    always_ff @(posedge clk_i)
    begin
      if (rst || tx_clr)
      begin
        txw_q <= 4'h0;
        txr_q <= 4'h0;
        txn_q <= 5'h00;
      end
      else
      begin
        if (tx_push)
          txm[txw_q] <= lat_data_q;
        txw_q <= txw_q + 4'(tx_push);
        txr_q <= txr_q + 4'(tx_pop);
        txn_q <= txn_q + 5'(tx_push) - 5'(tx_pop);
      end
    end
    always_ff @(posedge clk_i)
    begin
      if (rst || rx_clr)
      begin
        rxw_q <= 4'h0;
        rxr_q <= 4'h0;
        rxn_q <= 5'h00;
      end
      else
      begin
        if (rx_push)
          rxm[rxw_q] <= txm[txr_q];
        rxw_q <= rxw_q + 4'(rx_push);
        rxr_q <= rxr_q + 4'(rx_pop);
        rxn_q <= rxn_q + 5'(rx_push) - 5'(rx_pop);
      end
    end

    always_ff @(posedge clk_i)
    begin
      if (rst)
      begin
        ser_tx_o[c] <= 1'b1;
        rxl_q       <= 1'b1;
      end
      else
      begin
        ser_tx_o[c] <= ~lctl_q[uart_port_pkg::LCTL_BREAK_BIT] |
                       mctl_q[uart_port_pkg::MCTL_LOOP_BIT];
        rxl_q       <= ser_rx_i[c];
      end
    end
    assign irq_src[c] = (ien_q[uart_port_pkg::IEN_RX_BIT] & ~rx_empty) |
                        (ien_q[uart_port_pkg::IEN_TX_BIT] & tx_empty);
    assign irq_en[c]  = mctl_q[uart_port_pkg::MCTL_IRQEN_BIT];
    // read view of this channel
    always_comb
    begin
      case (lat_addr_q)
        uart_port_pkg::REG_DATA:    rval[c] = rx_empty ? 8'h00 : rxm[rxr_q];
        uart_port_pkg::REG_IEN:     rval[c] = ien_q;
        uart_port_pkg::REG_FCTL:    rval[c] = {5'h00, ~rx_empty, tx_empty, ~irq_src[c]};
        uart_port_pkg::REG_LCTL:    rval[c] = lctl_q;
        uart_port_pkg::REG_MCTL:    rval[c] = mctl_q;
        uart_port_pkg::REG_LSTAT:   rval[c] = {1'b0, tx_empty, ~tx_full, 4'h0, ~rx_empty};
        uart_port_pkg::REG_MSTAT:   rval[c] = {7'h00, rxl_q};
        default:                    rval[c] = spr_q;
      endcase
    end
  end

  // ------------------------------------------------------------
  // read data and interrupt pins
  // ------------------------------------------------------------
  logic [7:0] rmux;
  // drive only one channel; a multi-select read floats the bus
  always_comb
  begin
    rmux = 8'h00;
    for (int c = 0; c < NC; c++)
      if (lat_sel_q[c])
        rmux = rmux | rval[c];
  end
  always_ff @(posedge clk_i)
  begin
    if (rst)
    begin
      link.ddata    <= 8'h00;
      link.ddata_oe <= 1'b0;
      link.irq      <= 4'h0;
      link.irq_oe   <= 4'h0;
    end
    else
    begin
      link.ddata    <= rmux;
      link.ddata_oe <= rd & act_q & one_hot;
      // irq active high on strobe bus, active low on rw bus
      link.irq      <= strobe_mode_q ? irq_src : ~irq_src;
      link.irq_oe   <= strobe_mode_q ? ({NC{link.irq_style_strap}} | irq_en) : 4'hF;
    end
  end
endmodule
`default_nettype wire

/* File: logic/uart_host_end.sv */
// host end: drives straps, reset pulse and bus cycles into the quad uart
`timescale 1ns/1ps
`default_nettype none
module uart_host_end (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  uart_port_if.host       link,
  input  wire logic       style_sel_i,
  input  wire logic       irq_style_i,
  input  wire logic       rst_req_i,
  input  wire logic       cmd_valid_i,
  input  wire logic       cmd_write_i,
  input  wire logic       cmd_all_i,
  input  wire logic [1:0] cmd_chan_i,
  input  wire logic [2:0] cmd_addr_i,
  input  wire logic [7:0] cmd_wdata_i,
  output logic            cmd_ready_o,
  output logic      [7:0] rdata_o,
  output logic            rdata_valid_o,
  output logic      [3:0] irq_o
);
  typedef enum logic [2:0] {IDLE, SETUP, ACT, HOLD, RSTP} hstate_t;
  hstate_t    st_q;
  logic [3:0] cnt_q;
  logic       wr_q;
  logic [3:0] csel;
  logic       all_ok;

  assign all_ok = cmd_all_i & cmd_write_i & style_sel_i;
  assign csel   = all_ok ? 4'hF : (4'h1 << cmd_chan_i);

  // ------------------------------------------------------------
  // bus sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      st_q                 <= IDLE;
      cnt_q                <= 4'h0;
      wr_q                 <= 1'b0;
      cmd_ready_o          <= 1'b0;
      rdata_o              <= 8'h00;
      rdata_valid_o        <= 1'b0;
      irq_o                <= 4'h0;
      link.strap_val       <= 1'b1;
      link.strap_oe        <= 1'b0;
      link.irq_style_strap <= 1'b0;
      link.reset_pin       <= 1'b0;
      link.read_strobe_n   <= 1'b1;
      link.write_strobe_n  <= 1'b1;
      {link.chan_d_select_n, link.chan_c_select_n,
       link.chan_b_select_n, link.chan_a_select_n} <= 4'hF;
      link.unit_select_n   <= 1'b1;
      link.read_write_n    <= 1'b1;
      link.chan_addr_lo    <= 1'b0;
      link.chan_addr_hi    <= 1'b0;
      link.reg_addr        <= 3'h0;
      link.hdata           <= 8'h00;
      link.hdata_oe        <= 1'b0;
    end
    else
    begin
      link.strap_val       <= style_sel_i;
      link.strap_oe        <= 1'b1;
      link.irq_style_strap <= irq_style_i;
      rdata_valid_o        <= 1'b0;
      irq_o                <= link.irq_oe & (style_sel_i ? link.irq : ~link.irq);
      case (st_q)
        IDLE:
        begin
          link.reset_pin <= ~style_sel_i;
          cmd_ready_o    <= 1'b1;
          if (cmd_ready_o && rst_req_i)
          begin
            cmd_ready_o    <= 1'b0;
            link.reset_pin <= style_sel_i;
            cnt_q          <= 4'(uart_port_pkg::RST_DRIVE_CYC - 1);
            st_q           <= RSTP;
          end
          else if (cmd_ready_o && cmd_valid_i)
          begin
            cmd_ready_o       <= 1'b0;
            wr_q              <= cmd_write_i;
            link.reg_addr     <= cmd_addr_i;
            link.hdata        <= cmd_wdata_i;
            link.read_write_n <= ~cmd_write_i;
            {link.chan_addr_hi, link.chan_addr_lo} <= cmd_chan_i;
            if (style_sel_i)
              {link.chan_d_select_n, link.chan_c_select_n,
               link.chan_b_select_n, link.chan_a_select_n} <= ~csel;
            st_q <= SETUP;
          end
        end
        SETUP:
        begin
          link.read_strobe_n  <= ~(style_sel_i & ~wr_q);
          link.write_strobe_n <= ~(style_sel_i & wr_q);
          link.unit_select_n  <= style_sel_i;
          link.hdata_oe       <= wr_q;
          cnt_q               <= 4'(uart_port_pkg::STROBE_CYC - 1);
          st_q                <= ACT;
        end
        ACT:
        begin
          if (cnt_q == 4'h0)
          begin
            rdata_o             <= link.data_bus;
            link.read_strobe_n  <= 1'b1;
            link.write_strobe_n <= 1'b1;
            link.unit_select_n  <= 1'b1;
            st_q                <= HOLD;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        end
        HOLD:
        begin
          // data and selects held one cycle past the trailing edge
          link.hdata_oe <= 1'b0;
          {link.chan_d_select_n, link.chan_c_select_n,
           link.chan_b_select_n, link.chan_a_select_n} <= 4'hF;
          rdata_valid_o <= ~wr_q;
          cmd_ready_o   <= 1'b1;
          st_q          <= IDLE;
        end
        RSTP:
        begin
          if (cnt_q == 4'h0)
          begin
            link.reset_pin <= ~style_sel_i;
            st_q           <= HOLD;
            wr_q           <= 1'b1;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        end
        default:
          st_q <= IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: bench/uart_port_properties.sv */
// concurrent checks on the host port wires between the two ends
`timescale 1ns/1ps
`default_nettype none
module uart_port_properties (
  input wire logic       clk_i,
  input wire logic       nrst_i,
  input wire logic       bus_style,
  input wire logic       strap_oe,
  input wire logic       irq_style_strap,
  input wire logic       reset_pin,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic       chan_a_select_n,
  input wire logic       chan_b_select_n,
  input wire logic       chan_c_select_n,
  input wire logic       chan_d_select_n,
  input wire logic       unit_select_n,
  input wire logic       read_write_n,
  input wire logic       hdata_oe,
  input wire logic       ddata_oe,
  input wire logic [3:0] irq_oe
);
  // decoded bus state; reset polarity follows the strap
  wire       pin_act = bus_style ? reset_pin : !reset_pin;
  wire [2:0] n_sel   = {2'h0, !chan_a_select_n} + {2'h0, !chan_b_select_n}
                     + {2'h0, !chan_c_select_n} + {2'h0, !chan_d_select_n};
  wire       rd_open = bus_style ? (!read_strobe_n && n_sel == 3'h1)
                                 : (!unit_select_n && read_write_n);
  logic [2:0] quiet_q;

  // cycles since any reset, saturating so late outputs settle first
  always_ff @(posedge clk_i)
    if (!nrst_i || pin_act)
      quiet_q <= 3'h0;
    else if (quiet_q != 3'h4)
      quiet_q <= quiet_q + 3'h1;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  strap_pullup_a: assert property (!strap_oe |-> bus_style)
    else $error("bus strap not high while undriven");
  rd_drive_a: assert property (rd_open [*2] |-> ##[0:2] ddata_oe)
    else $error("device did not drive a selected read");
  ddata_release_a: assert property (!rd_open [*3] |-> !ddata_oe)
    else $error("device drives bus with no open read");
  no_contention_a: assert property (!(hdata_oe && ddata_oe))
    else $error("both ends drive the data bus");
  rst_quiet_a: assert property (pin_act [*2] |=> !ddata_oe)
    else $error("data output not released in reset");
  rst_width_a: assert property ($fell(pin_act) && bus_style == $past(bus_style, 2)
    |-> $past(pin_act, 2))
    else $error("reset pulse shorter than two cycles");
  one_read_sel_a: assert property (bus_style && !read_strobe_n |-> n_sel <= 3'h1)
    else $error("read with several channels selected");
  strobe_sel_a: assert property (bus_style && !(read_strobe_n && write_strobe_n)
    |-> n_sel != 3'h0)
    else $error("strobe active with no channel selected");
  irq_cont_a: assert property ((quiet_q == 3'h4 && irq_style_strap) [*3]
    |-> irq_oe == 4'hF)
    else $error("interrupt outputs not driven continuously");

  // main scenarios reached
  all_write_c: cover property (bus_style && n_sel == 3'h4 && !write_strobe_n);
  rw_read_c: cover property (!bus_style && rd_open);
  pin_reset_c: cover property (pin_act [*2]);
endmodule
`default_nettype wire

/* File: bench/quad_uart_host_port_config_tb.sv */
// self-checking bench: host end driving the quad uart device end
`timescale 1ns/1ps
`default_nettype none
module quad_uart_host_port_config_tb;
  typedef struct packed {
    logic       wr;
    logic [1:0] ch;
    logic [2:0] ad;
    logic [7:0] wd;
    logic [7:0] ex;
  } row_t;

  logic       clk_i;
  logic       nrst_i;
  logic       style_sel;
  logic       irq_style;
  logic       rst_req;
  logic       cmd_valid;
  logic       cmd_write;
  logic       cmd_all;
  logic [1:0] cmd_chan;
  logic [2:0] cmd_addr;
  logic [7:0] cmd_wdata;
  logic       cmd_ready;
  logic [7:0] rdata;
  logic       rdata_valid;
  logic [3:0] irq;
  logic [3:0] ser_rx;
  logic [3:0] ser_tx;
  logic       rvalid_seen;
  int         err_total;
  int         tests_run;
  row_t       rows [11];

  // the two ends facing each other, checker beside the wires
  uart_port_if link ();
  quad_uart_port i_quad_uart_port (.clk_i(clk_i), .nrst_i(nrst_i), .link(link),
    .ser_rx_i(ser_rx), .ser_tx_o(ser_tx));
  uart_host_end i_uart_host_end (.clk_i(clk_i), .nrst_i(nrst_i), .link(link),
    .style_sel_i(style_sel), .irq_style_i(irq_style), .rst_req_i(rst_req),
    .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_all_i(cmd_all),
    .cmd_chan_i(cmd_chan), .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
    .cmd_ready_o(cmd_ready), .rdata_o(rdata), .rdata_valid_o(rdata_valid), .irq_o(irq));
  uart_port_properties i_uart_port_properties (.clk_i(clk_i), .nrst_i(nrst_i),
    .bus_style(link.bus_style), .strap_oe(link.strap_oe),
    .irq_style_strap(link.irq_style_strap), .reset_pin(link.reset_pin),
    .read_strobe_n(link.read_strobe_n), .write_strobe_n(link.write_strobe_n),
    .chan_a_select_n(link.chan_a_select_n), .chan_b_select_n(link.chan_b_select_n),
    .chan_c_select_n(link.chan_c_select_n), .chan_d_select_n(link.chan_d_select_n),
    .unit_select_n(link.unit_select_n), .read_write_n(link.read_write_n),
    .hdata_oe(link.hdata_oe), .ddata_oe(link.ddata_oe), .irq_oe(link.irq_oe));

  // 10 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic complete_run();
    if (err_total == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // bounded wait; a hung host ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1)
    begin
      @(negedge clk_i);
      n++;
      if (n > 50)
      begin
        err_total++;
        complete_run();
      end
    end
  endtask

  // one request held for a single edge, then wait for completion
  task automatic issue(input logic rq, input logic wr, input logic al, input logic [1:0] ch,
                       input logic [2:0] ad, input logic [7:0] wd);
    wait_ready();
    rst_req = rq;
    cmd_valid = !rq;
    cmd_write = wr;
    cmd_all = al;
    cmd_chan = ch;
    cmd_addr = ad;
    cmd_wdata = wd;
    @(negedge clk_i);
    rst_req = 1'b0;
    cmd_valid = 1'b0;
    @(negedge clk_i);
    wait_ready();
    // valid pulse stands only in the cycle in which ready returns
    rvalid_seen = rdata_valid;
    repeat (2) @(negedge clk_i);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    nrst_i = 1'b0;
    style_sel = 1'b1;
    irq_style = 1'b1;
    rst_req = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_all = 1'b0;
    cmd_chan = 2'h0;
    cmd_addr = 3'h0;
    cmd_wdata = 8'h00;
    ser_rx = 4'h5;
    err_total = 0;
    tests_run = 0;
    // per channel scratch, defaults and receive level
    rows = '{'{1'b1, 2'h0, 3'h7, 8'h11, 8'h00}, '{1'b1, 2'h1, 3'h7, 8'h22, 8'h00},
             '{1'b1, 2'h2, 3'h7, 8'h33, 8'h00}, '{1'b1, 2'h3, 3'h7, 8'h44, 8'h00},
             '{1'b0, 2'h0, 3'h7, 8'h00, 8'h11}, '{1'b0, 2'h1, 3'h7, 8'h00, 8'h22},
             '{1'b0, 2'h2, 3'h7, 8'h00, 8'h33}, '{1'b0, 2'h3, 3'h7, 8'h00, 8'h44},
             '{1'b0, 2'h1, 3'h3, 8'h00, 8'h00}, '{1'b0, 2'h0, 3'h6, 8'h00, 8'h01},
             '{1'b0, 2'h1, 3'h6, 8'h00, 8'h00}};
    repeat (12) @(negedge clk_i);
    chk("strap", 8'h01, {7'h0, link.bus_style});
    nrst_i = 1'b1;
    // both bus styles; strap changes only ahead of a reset pulse
    for (int s = 1; s >= 0; s--)
    begin
      style_sel = s[0];
      issue(1'b1, 1'b0, 1'b0, 2'h0, 3'h0, 8'h00);
      chk("style", {7'h0, s[0]}, {7'h0, link.bus_style});
      foreach (rows[i])
      begin
        issue(1'b0, rows[i].wr, 1'b0, rows[i].ch, rows[i].ad, rows[i].wd);
        if (!rows[i].wr)
        begin
          chk("row", rows[i].ex, rdata);
          chk("rvalid", 8'h01, {7'h0, rvalid_seen});
        end
      end
      // transmit-empty interrupt on channel d, level per bus style
      issue(1'b0, 1'b1, 1'b0, 2'h3, 3'h1, 8'h02);
      chk("irq_level", 8'h08, {4'h0, irq});
    end
    style_sel = 1'b1;
    issue(1'b1, 1'b0, 1'b0, 2'h0, 3'h0, 8'h00);
    // write to all four channels at once
    issue(1'b0, 1'b1, 1'b1, 2'h0, 3'h7, 8'h5A);
    for (int c = 0; c < 4; c++)
    begin
      issue(1'b0, 1'b0, 1'b0, c[1:0], 3'h7, 8'h00);
      chk("all_write", 8'h5A, rdata);
    end
    // overfill transmit queue; the seventeenth byte is dropped
    for (int i = 0; i < 17; i++)
      issue(1'b0, 1'b1, 1'b0, 2'h1, 3'h0, 8'h30 + 8'(i));
    issue(1'b0, 1'b0, 1'b0, 2'h1, 3'h5, 8'h00);
    chk("lstat_full", 8'h00, rdata);
    issue(1'b0, 1'b1, 1'b0, 2'h1, 3'h4, 8'h10);
    repeat (20) @(negedge clk_i);
    issue(1'b0, 1'b0, 1'b0, 2'h1, 3'h5, 8'h00);
    chk("lstat_moved", 8'h61, rdata);
    for (int i = 0; i < 17; i++)
    begin
      issue(1'b0, 1'b0, 1'b0, 2'h1, 3'h0, 8'h00);
      chk("rx_data", (i < 16) ? 8'h30 + 8'(i) : 8'h00, rdata);
    end
    // transmit clear empties a loaded queue
    issue(1'b0, 1'b1, 1'b0, 2'h0, 3'h0, 8'hA5);
    issue(1'b0, 1'b0, 1'b0, 2'h0, 3'h5, 8'h00);
    chk("lstat_loaded", 8'h20, rdata);
    issue(1'b0, 1'b1, 1'b0, 2'h0, 3'h2, 8'h04);
    issue(1'b0, 1'b0, 1'b0, 2'h0, 3'h5, 8'h00);
    chk("lstat_clr", 8'h60, rdata);
    // interrupt drive under software and continuous styles
    irq_style = 1'b0;
    repeat (4) @(negedge clk_i);
    chk("irq_oe_off", 8'h00, {4'h0, link.irq_oe});
    issue(1'b0, 1'b1, 1'b0, 2'h0, 3'h4, 8'h08);
    chk("irq_oe_ch0", 8'h01, {4'h0, link.irq_oe});
    issue(1'b0, 1'b1, 1'b0, 2'h0, 3'h1, 8'h02);
    chk("irq_txempty", 8'h01, {4'h0, irq});
    irq_style = 1'b1;
    repeat (4) @(negedge clk_i);
    chk("irq_oe_cont", 8'h0F, {4'h0, link.irq_oe});
    // break on one channel, then a reset pulse restores defaults
    issue(1'b0, 1'b1, 1'b0, 2'h2, 3'h3, 8'h40);
    chk("tx_break", 8'h0B, {4'h0, ser_tx});
    issue(1'b1, 1'b0, 1'b0, 2'h0, 3'h0, 8'h00);
    chk("tx_idle", 8'h0F, {4'h0, ser_tx});
    issue(1'b0, 1'b0, 1'b0, 2'h2, 3'h3, 8'h00);
    chk("lctl_dflt", 8'h00, rdata);
    issue(1'b0, 1'b0, 1'b0, 2'h0, 3'h7, 8'h00);
    chk("scr_dflt", 8'h00, rdata);
    complete_run();
  end
endmodule
`default_nettype wire
